// ---- design/split_dual_8bit_timer_regs.sv ----
// Purpose: Register side and counting of a 16-bit timer split into two 8-bit timers.
// Assumes: Byte register port on clk; debug_halt comes from logic on clk.
// Notes:   Prescaler fixed at divide by one; waveform outputs are not built.
// Functional notes
// - Command field always reads back zero.
// - Commands: none, reserved, restart, hard reset.
// - Hard reset ignored while timer enabled.
// - Target field: none, reserved, reserved, both.
// - Hard reset needs both timers targeted together.
// - Set alias sets bits written one.
// - Clear alias clears bits written one.
// - Enables gate flags onto the interrupt.
// - Low compare flag sets on counter match.
// - Flags cleared by writing one or by hard reset.
// - High underflow flag sets at high bottom.
// - Low underflow flag sets at low bottom.
// - Debug halt stops timer unless run bit.
// - Counter writes beat count, clear, reload.
// - Low period holds top, resets to ones.
// - High period holds top, resets to ones.
// - Three low compare registers compared on every count tick.
// - Mode bit selects the split 8-bit operation.
`timescale 1ns/1ps
module split_dual_8bit_timer_regs
	import split_timer_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [5:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       debug_halt,
	output logic      [7:0] rd_data_r,
	output logic            irq_r
);
	// ************************************************************
	// Declarations
	// ************************************************************
	logic       enable_r, enable_nxt;
	logic       split_r, split_nxt;
	logic [1:0] target_r, target_nxt;
	logic [7:0] int_en_r, int_en_nxt;
	logic       dbg_run_r, dbg_run_nxt;
	logic [7:0] low_per_r, low_per_nxt;
	logic [7:0] high_per_r, high_per_nxt;
	logic [7:0] low_cmp_r [NUM_LOW_CMP], low_cmp_nxt [NUM_LOW_CMP];
	logic [7:0] rd_nxt;
	logic       irq_nxt;
	logic       wr_ctrl_a, wr_ctrl_d, wr_clr, wr_set, wr_int_en, wr_flags;
	logic       wr_debug, wr_low_cnt, wr_high_cnt, wr_low_per, wr_high_per;
	logic [2:0] wr_cmp;
	command_t   cmd;
	logic       restart_cmd, hard_cmd, tick;
	logic [7:0] low_cnt, high_cnt;
	logic       low_unf, high_unf;
	logic [7:0] flag_set, flag_clr, flags;

	// ************************************************************
	// Write decode and commands
	// ************************************************************
	always_comb
	begin
		wr_ctrl_a   = 1'b0;
		wr_ctrl_d   = 1'b0;
		wr_clr      = 1'b0;
		wr_set      = 1'b0;
		wr_int_en   = 1'b0;
		wr_flags    = 1'b0;
		wr_debug    = 1'b0;
		wr_low_cnt  = 1'b0;
		wr_high_cnt = 1'b0;
		wr_low_per  = 1'b0;
		wr_high_per = 1'b0;
		wr_cmp      = 3'h0;
		if (!reg_wr)
			wr_cmp = 3'h0;
		else if (reg_addr == OFF_CTRL_A)
			wr_ctrl_a = 1'b1;
		else if (reg_addr == OFF_CTRL_D)
			wr_ctrl_d = 1'b1;
		else if (reg_addr == OFF_CTRLE_CLR)
			wr_clr = 1'b1;
		else if (reg_addr == OFF_CTRLE_SET)
			wr_set = 1'b1;
		else if (reg_addr == OFF_INT_EN)
			wr_int_en = 1'b1;
		else if (reg_addr == OFF_INT_FLAGS)
			wr_flags = 1'b1;
		else if (reg_addr == OFF_DEBUG)
			wr_debug = 1'b1;
		else if (reg_addr == OFF_LOW_CNT)
			wr_low_cnt = 1'b1;
		else if (reg_addr == OFF_HIGH_CNT)
			wr_high_cnt = 1'b1;
		else if (reg_addr == OFF_LOW_PER)
			wr_low_per = 1'b1;
		else if (reg_addr == OFF_HIGH_PER)
			wr_high_per = 1'b1;
		else if (reg_addr == OFF_LOW_CMP0)
			wr_cmp = 3'h1;
		else if (reg_addr == OFF_LOW_CMP0 + OFF_CMP_STRIDE)
			wr_cmp = 3'h2;
		else if (reg_addr == OFF_LOW_CMP0 + OFF_CMP_STRIDE + OFF_CMP_STRIDE)
			wr_cmp = 3'h4;
	end

	always_comb
	begin
		cmd = command_t'(reg_wdata[CMD_LSB +: 2]);
		restart_cmd = wr_set && cmd == CMD_RESTART
			&& reg_wdata[TARGET_LSB +: 2] == TARGET_BOTH;
		hard_cmd = wr_set && cmd == CMD_HARD_RESET && !enable_r
			&& reg_wdata[TARGET_LSB +: 2] == TARGET_BOTH;
	end

	always_comb
	begin
		tick = enable_r && split_r && (!debug_halt || dbg_run_r);
	end

	// ************************************************************
	// Control and configuration registers
	// ************************************************************
	always_comb
	begin
		enable_nxt   = enable_r;
		split_nxt    = split_r;
		target_nxt   = target_r;
		int_en_nxt   = int_en_r;
		dbg_run_nxt  = dbg_run_r;
		low_per_nxt  = low_per_r;
		high_per_nxt = high_per_r;
		for (int n = 0; n < NUM_LOW_CMP; n++)
		begin
			low_cmp_nxt[n] = low_cmp_r[n];
			if (wr_cmp[n])
				low_cmp_nxt[n] = reg_wdata;
			else if (hard_cmd)
				low_cmp_nxt[n] = CMP_RESET;
		end
		if (wr_ctrl_a)
			enable_nxt = reg_wdata[BIT_ENABLE];
		if (wr_ctrl_d)
			split_nxt = reg_wdata[BIT_SPLIT];
		if (wr_set)
			target_nxt = target_r | reg_wdata[TARGET_LSB +: 2];
		if (wr_clr)
			target_nxt = target_r & ~reg_wdata[TARGET_LSB +: 2];
		if (wr_int_en)
			int_en_nxt = reg_wdata & INT_MASK;
		if (wr_debug)
			dbg_run_nxt = reg_wdata[BIT_RUN_DBG];
		if (wr_low_per)
			low_per_nxt = reg_wdata;
		else if (hard_cmd)
			low_per_nxt = PERIOD_RESET;
		if (wr_high_per)
			high_per_nxt = reg_wdata;
		else if (hard_cmd)
			high_per_nxt = PERIOD_RESET;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			enable_r   <= 1'b0;
			split_r    <= 1'b0;
			target_r   <= TARGET_NONE;
			int_en_r   <= REG_RESET;
			dbg_run_r  <= 1'b0;
			low_per_r  <= PERIOD_RESET;
			high_per_r <= PERIOD_RESET;
			for (int n = 0; n < NUM_LOW_CMP; n++)
				low_cmp_r[n] <= CMP_RESET;
		end
		else
		begin
			enable_r   <= enable_nxt;
			split_r    <= split_nxt;
			target_r   <= target_nxt;
			int_en_r   <= int_en_nxt;
			dbg_run_r  <= dbg_run_nxt;
			low_per_r  <= low_per_nxt;
			high_per_r <= high_per_nxt;
			for (int n = 0; n < NUM_LOW_CMP; n++)
				low_cmp_r[n] <= low_cmp_nxt[n];
		end
	end

	// ************************************************************
	// Counters
	// ************************************************************
	down_counter8 low_counter (
		.clk       (clk),
		.rst_b     (rst_b),
		.tick      (tick),
		.wr_en     (wr_low_cnt),
		.wr_val    (reg_wdata),
		.restart   (restart_cmd),
		.hard_clr  (hard_cmd),
		.period    (low_per_r),
		.count_r   (low_cnt),
		.underflow (low_unf)
	);

	down_counter8 high_counter (
		.clk       (clk),
		.rst_b     (rst_b),
		.tick      (tick),
		.wr_en     (wr_high_cnt),
		.wr_val    (reg_wdata),
		.restart   (restart_cmd),
		.hard_clr  (hard_cmd),
		.period    (high_per_r),
		.count_r   (high_cnt),
		.underflow (high_unf)
	);

	// ************************************************************
	// Interrupt flags
	// ************************************************************
	always_comb
	begin
		flag_set = 8'h00;
		flag_set[FLAG_LOW_UNF] = low_unf;
		flag_set[FLAG_HIGH_UNF] = high_unf;
		for (int n = 0; n < NUM_LOW_CMP; n++)
			flag_set[FLAG_LOW_CMP0 + n] = tick && low_cnt == low_cmp_r[n];
		flag_clr = (wr_flags ? reg_wdata : 8'h00) | {8{hard_cmd}};
	end

	for (genvar gi = 0; gi < 8; gi++)
	begin : g_flag
		if (INT_MASK[gi])
		begin : g_used
			sticky_flag flag_bit (
				.clk    (clk),
				.rst_b  (rst_b),
				.set    (flag_set[gi]),
				.clr    (flag_clr[gi]),
				.flag_r (flags[gi])
			);
		end
		else
		begin : g_unused
			assign flags[gi] = 1'b0;
		end
	end

	// ************************************************************
	// Read data and interrupt output
	// ************************************************************
	always_comb
	begin
		irq_nxt = |(flags & int_en_r);
		rd_nxt  = 8'h00;
		if (reg_addr == OFF_CTRL_A)
			rd_nxt[BIT_ENABLE] = enable_r;
		else if (reg_addr == OFF_CTRL_D)
			rd_nxt[BIT_SPLIT] = split_r;
		else if (reg_addr == OFF_CTRLE_CLR || reg_addr == OFF_CTRLE_SET)
			rd_nxt[TARGET_LSB +: 2] = target_r;
		else if (reg_addr == OFF_INT_EN)
			rd_nxt = int_en_r;
		else if (reg_addr == OFF_INT_FLAGS)
			rd_nxt = flags;
		else if (reg_addr == OFF_DEBUG)
			rd_nxt[BIT_RUN_DBG] = dbg_run_r;
		else if (reg_addr == OFF_LOW_CNT)
			rd_nxt = low_cnt;
		else if (reg_addr == OFF_HIGH_CNT)
			rd_nxt = high_cnt;
		else if (reg_addr == OFF_LOW_PER)
			rd_nxt = low_per_r;
		else if (reg_addr == OFF_HIGH_PER)
			rd_nxt = high_per_r;
		else if (reg_addr == OFF_LOW_CMP0)
			rd_nxt = low_cmp_r[0];
		else if (reg_addr == OFF_LOW_CMP0 + OFF_CMP_STRIDE)
			rd_nxt = low_cmp_r[1];
		else if (reg_addr == OFF_LOW_CMP0 + OFF_CMP_STRIDE + OFF_CMP_STRIDE)
			rd_nxt = low_cmp_r[2];
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_data_r <= 8'h00;
			irq_r     <= 1'b0;
		end
		else
		begin
			rd_data_r <= rd_nxt;
			irq_r     <= irq_nxt;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	cmd_reads_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_addr == OFF_CTRLE_SET || reg_addr == OFF_CTRLE_CLR) |=> rd_data_r[3:2] == 2'h0)
		else $error("command field read back non-zero");
	restart_reload_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_set && reg_wdata[3:0] == 4'hb)
		|=> low_cnt == $past(low_per_r) && high_cnt == $past(high_per_r))
		else $error("restart did not reload both counters");
	hard_ignored_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_set && reg_wdata[3:0] == 4'hf && enable_r) |=> low_per_r == $past(low_per_r))
		else $error("hard reset acted while enabled");
	hard_applied_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_set && reg_wdata[3:0] == 4'hf && !enable_r)
		|=> low_per_r == 8'hff && high_per_r == 8'hff && flags == 8'h00 && low_cnt == 8'h00)
		else $error("hard reset did not restore registers");
	hard_needs_both_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_set && reg_wdata[3:2] == 2'h3 && reg_wdata[1:0] != 2'h3) |=> $stable(low_per_r))
		else $error("hard reset acted without both targets");
	set_alias_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_set |=> target_r == ($past(target_r) | $past(reg_wdata[1:0])))
		else $error("set alias wrong");
	clear_alias_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_clr |=> target_r == ($past(target_r) & ~$past(reg_wdata[1:0])))
		else $error("clear alias wrong");
	irq_gating_a: assert property (@(posedge clk) disable iff (!rst_b)
		(int_en_r == 8'h00) |=> !irq_r)
		else $error("interrupt raised with all enables off");
	compare_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && low_cnt == low_cmp_r[1]) |=> flags[FLAG_LOW_CMP0 + 1])
		else $error("compare match did not set flag");
	debug_halt_a: assert property (@(posedge clk) disable iff (!rst_b)
		(debug_halt && !dbg_run_r && !reg_wr) |=> $stable(low_cnt) && $stable(high_cnt))
		else $error("counter moved during debug halt");
endmodule // split_dual_8bit_timer_regs

// ---- design/split_timer_pkg.sv ----
// Purpose: Shared offsets, fields and reset values of the split-mode dual 8-bit timer.
// Assumes: Byte-wide register port with 6-bit offsets.
// Notes:   The offsets, fields, masks, reset values and encodings used by the timer files are named here.
package split_timer_pkg;
	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [5:0] OFF_CTRL_A     = 6'h00;
	localparam logic [5:0] OFF_CTRL_D     = 6'h03;
	localparam logic [5:0] OFF_CTRLE_CLR  = 6'h04;
	localparam logic [5:0] OFF_CTRLE_SET  = 6'h05;
	localparam logic [5:0] OFF_INT_EN     = 6'h0a;
	localparam logic [5:0] OFF_INT_FLAGS  = 6'h0b;
	localparam logic [5:0] OFF_DEBUG      = 6'h0e;
	localparam logic [5:0] OFF_LOW_CNT    = 6'h20;
	localparam logic [5:0] OFF_HIGH_CNT   = 6'h21;
	localparam logic [5:0] OFF_LOW_PER    = 6'h26;
	localparam logic [5:0] OFF_HIGH_PER   = 6'h27;
	localparam logic [5:0] OFF_LOW_CMP0   = 6'h28;
	localparam logic [5:0] OFF_CMP_STRIDE = 6'h02;
	localparam int         NUM_LOW_CMP    = 3;
	// ************************************************************
	// Field positions and masks
	// ************************************************************
	localparam int         BIT_ENABLE     = 0;
	localparam int         BIT_SPLIT      = 0;
	localparam int         BIT_RUN_DBG    = 0;
	localparam int         CMD_LSB        = 2;
	localparam int         TARGET_LSB     = 0;
	localparam int         FLAG_LOW_UNF   = 0;
	localparam int         FLAG_HIGH_UNF  = 1;
	localparam int         FLAG_LOW_CMP0  = 4;
	localparam logic [7:0] INT_MASK       = 8'h73;
	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] COUNT_RESET    = 8'h00;
	localparam logic [7:0] PERIOD_RESET   = 8'hff;
	localparam logic [7:0] CMP_RESET      = 8'h00;
	// ************************************************************
	// Command encodings
	// ************************************************************
	typedef enum logic [1:0] {
		CMD_NONE       = 2'h0,
		CMD_RESERVED   = 2'h1,
		CMD_RESTART    = 2'h2,
		CMD_HARD_RESET = 2'h3
	} command_t;
	localparam logic [1:0] TARGET_NONE    = 2'h0;
	localparam logic [1:0] TARGET_BOTH    = 2'h3;
endpackage

// ---- design/sticky_flag.sv ----
// Purpose: One interrupt flag that hardware sets and software clears.
// Assumes: Set and clear are single-cycle strobes on clk.
// Notes:   A set in the clearing cycle wins.
`timescale 1ns/1ps
module sticky_flag
	import split_timer_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_r
);
	logic flag_nxt;

	always_comb
	begin
		flag_nxt = set | (flag_r & ~clr);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			flag_r <= 1'b0;
		else
			flag_r <= flag_nxt;
	end

	flag_set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
		set |=> flag_r)
		else $error("flag lost a set event");
	flag_no_hw_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		(flag_r && !clr) |=> flag_r)
		else $error("flag cleared without software clear");
endmodule // sticky_flag

// ---- design/down_counter8.sv ----
// Purpose: One 8-bit down counter with reload from its period.
// Assumes: Tick is a one-cycle enable on clk.
// Notes:   Write beats hard clear, hard clear beats restart, restart beats count.
`timescale 1ns/1ps
module down_counter8
	import split_timer_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       tick,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_val,
	input  wire logic       restart,
	input  wire logic       hard_clr,
	input  wire logic [7:0] period,
	output logic      [7:0] count_r,
	output logic            underflow
);
	logic [7:0] count_nxt;

	always_comb
	begin
		count_nxt = count_r;
		underflow = 1'b0;
		if (wr_en)
			count_nxt = wr_val;
		else if (hard_clr)
			count_nxt = COUNT_RESET;
		else if (restart)
			count_nxt = period;
		else if (tick)
		begin
			if (count_r == COUNT_RESET)
			begin
				count_nxt = period;
				underflow = 1'b1;
			end
			else
				count_nxt = count_r - 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			count_r <= COUNT_RESET;
		else
			count_r <= count_nxt;
	end

	bottom_reload_a: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && !wr_en && !hard_clr && !restart && count_r == 8'h00)
		|=> count_r == $past(period))
		else $error("counter did not reload at bottom");
	write_priority_a: assert property (@(posedge clk) disable iff (!rst_b)
		wr_en |=> count_r == $past(wr_val))
		else $error("bus write lost against counter update");
endmodule // down_counter8

// ---- dv/split_dual_8bit_timer_regs_bench.sv ----
// Purpose: Self-checking bench for the split-mode dual 8-bit timer register block.
// Assumes: Inputs change 1 ns after the rising edge; read data lags the address by one edge.
// Notes:   Counting runs only in short bursts with the debug halt released or the run bit set, so counts are exact.
`timescale 1ns/1ps
module split_dual_8bit_timer_regs_bench
	import split_timer_pkg::*;
;
	logic       clk;
	logic       rst_b;
	logic [5:0] reg_addr;
	logic       reg_wr;
	logic [7:0] reg_wdata;
	logic       debug_halt;
	logic [7:0] rd_data_r;
	logic       irq_r;
	int         n_mismatch;
	int         checks_done;

	split_dual_8bit_timer_regs u_dut (
		.clk        (clk),
		.rst_b      (rst_b),
		.reg_addr   (reg_addr),
		.reg_wr     (reg_wr),
		.reg_wdata  (reg_wdata),
		.debug_halt (debug_halt),
		.rd_data_r  (rd_data_r),
		.irq_r      (irq_r)
	);

	always #5 clk = ~clk;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic finish_test();
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		reg_addr = a;
		@(posedge clk);
		#1;
		check($sformatf("register %h", a), rd_data_r, exp);
	endtask

	task automatic irq_is(input logic exp);
		repeat (3) @(posedge clk);
		#1;
		check("irq", {7'h00, irq_r}, {7'h00, exp});
	endtask

	task automatic run_ticks(input int n);
		debug_halt = 1'b0;
		repeat (n) @(posedge clk);
		#1;
		debug_halt = 1'b1;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_reset_values();
		rd(OFF_LOW_PER, 8'hff);
		rd(OFF_HIGH_PER, 8'hff);
		rd(OFF_LOW_CNT, 8'h00);
		rd(OFF_HIGH_CNT, 8'h00);
		rd(OFF_INT_EN, 8'h00);
		rd(OFF_INT_FLAGS, 8'h00);
		rd(OFF_DEBUG, 8'h00);
		rd(OFF_CTRLE_SET, 8'h00);
		rd(OFF_LOW_CMP0, 8'h00);
		rd(6'h30, 8'h00);
	endtask

	task automatic test_alias();
		wr(OFF_CTRLE_SET, 8'h0d);
		rd(OFF_CTRLE_SET, 8'h01);
		wr(OFF_CTRLE_SET, 8'h06);
		rd(OFF_CTRLE_SET, 8'h03);
		wr(OFF_CTRLE_CLR, 8'h01);
		rd(OFF_CTRLE_SET, 8'h02);
		rd(OFF_CTRLE_CLR, 8'h02);
		wr(OFF_CTRLE_CLR, 8'h03);
		rd(OFF_CTRLE_SET, 8'h00);
	endtask

	task automatic test_commands();
		wr(OFF_LOW_PER, 8'h05);
		wr(OFF_HIGH_PER, 8'h09);
		wr(OFF_CTRLE_SET, 8'h0b);
		rd(OFF_LOW_CNT, 8'h05);
		rd(OFF_HIGH_CNT, 8'h09);
		wr(OFF_LOW_CNT, 8'h02);
		wr(OFF_CTRLE_SET, 8'h07);
		wr(OFF_CTRLE_SET, 8'h08);
		wr(OFF_CTRLE_SET, 8'h09);
		wr(OFF_CTRLE_SET, 8'h0a);
		wr(OFF_CTRLE_SET, 8'h03);
		rd(OFF_LOW_CNT, 8'h02);
		rd(OFF_HIGH_CNT, 8'h09);
		wr(OFF_CTRLE_CLR, 8'h03);
	endtask

	task automatic test_counting();
		wr(OFF_LOW_CNT, 8'h03);
		wr(OFF_HIGH_CNT, 8'h09);
		wr(OFF_LOW_CMP0, 8'h02);
		wr(OFF_LOW_CMP0 + OFF_CMP_STRIDE, 8'h01);
		wr(OFF_LOW_CMP0 + 6'h04, 8'h07);
		wr(OFF_CTRL_A, 8'h01);
		run_ticks(2);
		rd(OFF_LOW_CNT, 8'h03);
		wr(OFF_CTRL_D, 8'h01);
		rd(OFF_CTRL_D, 8'h01);
		repeat (3) @(posedge clk);
		#1;
		rd(OFF_LOW_CNT, 8'h03);
		run_ticks(4);
		rd(OFF_LOW_CNT, 8'h05);
		rd(OFF_HIGH_CNT, 8'h05);
		rd(OFF_INT_FLAGS, 8'h31);
		run_ticks(6);
		rd(OFF_LOW_CNT, 8'h05);
		rd(OFF_HIGH_CNT, 8'h09);
		rd(OFF_INT_FLAGS, 8'h33);
		wr(OFF_DEBUG, 8'h01);
		wr(OFF_DEBUG, 8'h00);
		rd(OFF_LOW_CNT, 8'h03);
		rd(OFF_HIGH_CNT, 8'h07);
	endtask

	task automatic test_write_priority();
		reg_addr = OFF_LOW_CNT;
		reg_wdata = 8'h40;
		reg_wr = 1'b1;
		debug_halt = 1'b0;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		debug_halt = 1'b1;
		rd(OFF_LOW_CNT, 8'h40);
		rd(OFF_HIGH_CNT, 8'h06);
	endtask

	task automatic test_interrupts();
		irq_is(1'b0);
		wr(OFF_INT_EN, 8'h02);
		irq_is(1'b1);
		wr(OFF_INT_FLAGS, 8'h00);
		rd(OFF_INT_FLAGS, 8'h33);
		wr(OFF_INT_FLAGS, 8'h02);
		rd(OFF_INT_FLAGS, 8'h31);
		irq_is(1'b0);
		wr(OFF_INT_EN, 8'hff);
		rd(OFF_INT_EN, 8'h73);
		irq_is(1'b1);
	endtask

	task automatic test_hard_reset();
		wr(OFF_CTRLE_SET, 8'h0f);
		rd(OFF_LOW_PER, 8'h05);
		wr(OFF_CTRL_A, 8'h00);
		wr(OFF_CTRLE_SET, 8'h0c);
		wr(OFF_CTRLE_SET, 8'h0e);
		rd(OFF_LOW_PER, 8'h05);
		wr(OFF_CTRLE_SET, 8'h0f);
		rd(OFF_LOW_PER, 8'hff);
		rd(OFF_HIGH_PER, 8'hff);
		rd(OFF_LOW_CNT, 8'h00);
		rd(OFF_HIGH_CNT, 8'h00);
		rd(OFF_LOW_CMP0, 8'h00);
		rd(OFF_INT_FLAGS, 8'h00);
		rd(OFF_CTRLE_SET, 8'h03);
		irq_is(1'b0);
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		debug_halt = 1'b1;
		n_mismatch = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		#1;
		rst_b = 1'b1;
		test_reset_values();
		test_alias();
		test_commands();
		test_counting();
		test_write_priority();
		test_interrupts();
		test_hard_reset();
		finish_test();
	end

	initial
	begin
		repeat (2000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
endmodule // split_dual_8bit_timer_regs_bench
